// >>> rx_gain_and_channel_filter.sv
// rx gain control, decimating 16-tap channel filter and bandwidth maths
// Behaviour
// R01: wait state holds gain until level exceeds
// R02: six gain steps picked from input power
// R03: reference equals -174+7+8+10log(2bw)+5 dB
// R04: correction phase uses separate bandwidth setting
// R05: digital gain readjusts every two bits
// R06: software writes 0x10 or 0x30 to enable
// R07: digital gain runs in every data mode
// R08: digital gain adjusts while front gain frozen
// R09: one-bit I/Q streams decimated before stages
// R10: channel filter is sixteen-tap FIR
// R11: software keeps bit rate below 2x bandwidth
// R12: FSK bandwidth = ref/(mant*2^(exp+2))
// R13: OOK bandwidth = ref/(mant*2^(exp+3))
// R14: mantissa codes 00/01/10 give 16/20/24
// R15: image filter bypassed when scheme is 00
// R16: dc cutoff = 4bw/(2pi*2^(sel+2))
// R17: OOK low-IF at half the bandwidth
// R18: gain choice 000 automatic, others fixed; the code also leaves 111 to the automatic loop
// R19: wait ends after two samples above level
// R20: rearm bit restarts wait and gain selection
// R21: filter settings change at sample boundary
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module rx_gain_and_channel_filter
#(
   parameter int BIT_CYCLES = 4096,
   parameter int COEF_W     = 8
)
(
   input  wire logic                 clk_sys,
   input  wire logic                 nrst,
   input  wire rx_chain_pkg::wb_req_s wb_req,
   output      logic [31:0]          wb_dat_o,
   output      logic                 wb_ack_o,
   input  wire logic                 adc_i_bit,
   input  wire logic                 adc_q_bit,
   input  wire logic                 sample_tick,
   input  wire logic [7:0]           measured_signal_level,
   input  wire logic                 correction_active,
   input  wire logic                 packet_gain_frozen,
   output      logic [2:0]           front_gain_step,
   output      logic [15:0]          chan_i,
   output      logic [15:0]          chan_q,
   output      logic                 chan_valid,
   output      logic                 image_filter_on,
   output      logic [31:0]          if_offset_hz,
   output      logic [31:0]          dc_cutoff_hz
);

   // field widths of the state struct, declared ahead of it
   localparam int DGAIN_BITS_W = rx_chain_pkg::DGAIN_BITS;
   localparam int DECIM_W = rx_chain_pkg::DECIM_LOG2;
   localparam int FIR_BITS = rx_chain_pkg::FIR_TAPS * 8;

   // =====================================================================
   // state
   // =====================================================================
   typedef struct packed
   {
      logic [31:0] rdat;
      logic        ack;
      logic [1:0]  demod_scheme_select;
      logic [7:0]  bandwidth_config_reg;
      logic [7:0]  correction_bw;
      logic [7:0]  digital_gain_ctrl_reg;
      logic [2:0]  front_gain_choice;
      logic        rearm;
      logic [7:0]  signal_wait_level_reg;
      logic [39:0] step_levels;
      rx_chain_pkg::agc_state_e agc;
      logic        above_once;
      logic [2:0]  gain;
      logic [15:0] bit_cnt;
      logic        bit_half;
      logic [DGAIN_BITS_W-1:0] dgain;
      logic [7:0]  act_bw_cfg;
      logic [DECIM_W-1:0] dec_cnt;
      logic [7:0]  acc_i;
      logic [7:0]  acc_q;
      logic [FIR_BITS-1:0] line_i;
      logic [FIR_BITS-1:0] line_q;
      logic [15:0] out_i;
      logic [15:0] out_q;
      logic        valid;
      logic        img_on;
      logic [31:0] bw_hz;
      logic [31:0] ifo;
      logic [31:0] dcc;
   } state_s;

   state_s st;
   state_s next_st;

   // =====================================================================
   // helpers
   // =====================================================================
   // mantissa code to divisor; reserved code 11 treated as 24
   function automatic logic [4:0] mant_value(input logic [1:0] code);
      case (code)
         2'h0: mant_value = 5'h10;   // R14
         2'h1: mant_value = 5'h14;
         default: mant_value = 5'h18;
      endcase
   endfunction

   // single-side bandwidth in Hz for a config byte and scheme
   function automatic logic [31:0] bw_of(input logic [7:0] cfg,
                                          input logic [1:0] scheme);
      logic [4:0] sh;
      logic [31:0] den;
      sh = 5'(cfg[2:0]) + 5'h2;     // R12
      if (scheme != rx_chain_pkg::SCHEME_FSK)
         sh = sh + 5'h1;            // R13
      den = 32'(mant_value(cfg[rx_chain_pkg::MANT_LSB +: 2])) << sh;
      bw_of = 32'(rx_chain_pkg::XTAL_HZ) / den;
   endfunction

   // coarse 10log10 of a value in Hz, by leading-one position (3 dB/oct)
   function automatic logic signed [15:0] log_db(input logic [31:0] v);
      int msb;
      msb = 0;
      for (int k = 0; k < 32; k++)
         if (v[k])
            msb = k;
      log_db = 16'((msb * 301) / 100);
   endfunction

   // fir coefficient for tap k: symmetric triangle window
   function automatic logic [COEF_W-1:0] coef(input int k);
      int d;
      d = (k < 8) ? k + 1 : 16 - k;
      coef = COEF_W'(d);
   endfunction

   // step index from input power against five ascending levels
   function automatic logic [2:0] pick_step(input logic [7:0] lvl,
                                            input logic [39:0] thr);
      logic [2:0] s;
      s = 3'h1;
      for (int k = 0; k < 5; k++)
         if (lvl > thr[8*k +: 8])
            s = 3'(k + 2);
      pick_step = s;
   endfunction

   // =====================================================================
   // fir datapath: 16 decimated words per channel, summed with weights
   // =====================================================================
   logic [15:0] fir_i;
   logic [15:0] fir_q;
   always_comb
   begin
      fir_i = 16'h0000;
      fir_q = 16'h0000;
      for (int k = 0; k < rx_chain_pkg::FIR_TAPS; k++)
      begin
         fir_i = fir_i + 16'(st.line_i[8*k +: 8] * coef(k));   // R10
         fir_q = fir_q + 16'(st.line_q[8*k +: 8] * coef(k));
      end
   end

   // =====================================================================
   // next state
   // =====================================================================
   logic hit;
   logic [7:0] a8;
   logic [7:0] bw_sel;
   logic signed [15:0] ref_db;
   always_comb
   begin
      next_st = st;
      a8 = wb_req.adr[7:0];
      hit = wb_req.cyc && wb_req.stb && !st.ack;
      ref_db = 16'h0000;
      bw_sel = st.bandwidth_config_reg;
      next_st.ack = hit;
      next_st.valid = 1'b0;
      next_st.rearm = 1'b0;

      // bus writes, gated by sel[0] alone; every field but the 32-bit low step word sits in the lowest byte lane
      if (hit && wb_req.we && wb_req.sel[0])
      begin
         case (a8)
            rx_chain_pkg::OFS_MODULATION:
               next_st.demod_scheme_select = wb_req.dat[1:0];
            rx_chain_pkg::OFS_BANDWIDTH:
               next_st.bandwidth_config_reg = wb_req.dat[7:0];
            rx_chain_pkg::OFS_CORR_BW:
               next_st.correction_bw = wb_req.dat[7:0];
            rx_chain_pkg::OFS_DIGITAL_GAIN:
               next_st.digital_gain_ctrl_reg = wb_req.dat[7:0];   // R06
            rx_chain_pkg::OFS_GAIN_CTRL:
            begin
               next_st.front_gain_choice = wb_req.dat[6:4];
               next_st.rearm = wb_req.dat[rx_chain_pkg::REARM_BIT];
            end
            rx_chain_pkg::OFS_WAIT_LEVEL:
               next_st.signal_wait_level_reg = wb_req.dat[7:0];
            rx_chain_pkg::OFS_STEP_LO:
               next_st.step_levels[31:0] = wb_req.dat;
            rx_chain_pkg::OFS_STEP_HI:
               next_st.step_levels[39:32] = wb_req.dat[7:0];
            default: ;
         endcase
      end

      // agc loop; input levels arrive on sample_tick
      case (st.agc)
         rx_chain_pkg::ST_WAIT:
            if (sample_tick)
            begin
               if (measured_signal_level > st.signal_wait_level_reg)   // R01
               begin
                  next_st.above_once = 1'b1;
                  if (st.above_once)
                     next_st.agc = rx_chain_pkg::ST_PICK;   // R19
               end
               else
                  next_st.above_once = 1'b0;
            end
         rx_chain_pkg::ST_PICK:
         begin
            next_st.gain = pick_step(measured_signal_level,
                                     st.step_levels);   // R02
            next_st.agc = rx_chain_pkg::ST_HOLD;
         end
         rx_chain_pkg::ST_HOLD: ;
         default:
            next_st.agc = rx_chain_pkg::ST_WAIT;
      endcase
      if (st.rearm)
      begin
         next_st.agc = rx_chain_pkg::ST_WAIT;   // R20
         next_st.above_once = 1'b0;
      end

      // digital gain: independent of data mode and front gain freeze
      next_st.bit_cnt = st.bit_cnt + 16'h0001;
      if (st.bit_cnt >= 16'(BIT_CYCLES - 1))
      begin
         next_st.bit_cnt = 16'h0000;
         next_st.bit_half = !st.bit_half;
         if (st.bit_half &&
             st.digital_gain_ctrl_reg[rx_chain_pkg::DGAIN_ON_BIT])   // R05 R07 R08
         begin
            if (st.out_i[15:14] != 2'h0 && st.dgain != '0)
               next_st.dgain = st.dgain - 1'b1;
            else if (st.out_i[15:12] == 4'h0 && st.dgain != '1)
               next_st.dgain = st.dgain + 1'b1;
         end
      end

      // decimator: integrate one-bit streams, dump every 16 bits
      next_st.dec_cnt = st.dec_cnt + 1'b1;
      next_st.acc_i = st.acc_i + 8'(adc_i_bit);   // R09
      next_st.acc_q = st.acc_q + 8'(adc_q_bit);
      if (st.dec_cnt == '1)
      begin
         next_st.acc_i = 8'(adc_i_bit);
         next_st.acc_q = 8'(adc_q_bit);
         next_st.line_i = {st.line_i[FIR_BITS-9:0], st.acc_i};
         next_st.line_q = {st.line_q[FIR_BITS-9:0], st.acc_q};
         next_st.out_i = fir_i << st.dgain;
         next_st.out_q = fir_q << st.dgain;
         next_st.valid = 1'b1;
         // settings latch only here, between output samples
         bw_sel = correction_active ? st.correction_bw
                                    : st.bandwidth_config_reg;   // R04
         next_st.act_bw_cfg = bw_sel;   // R21
      end

      // derived quantities from the active setting
      next_st.bw_hz = bw_of(st.act_bw_cfg, st.demod_scheme_select);
      next_st.img_on = (st.demod_scheme_select
                        != rx_chain_pkg::SCHEME_FSK);   // R15
      next_st.ifo = st.img_on ? (st.bw_hz >> 1) : 32'h0;   // R17
      // 4bw/(2pi) ~ bw*163/256, then >> (sel+2)
      next_st.dcc = ((st.bw_hz * 32'hA3) >> 8)
                    >> (32'(st.act_bw_cfg[7:rx_chain_pkg::DCC_LSB]) + 2);   // R16
      ref_db = 16'(rx_chain_pkg::REF_FIXED_DB)
               + log_db(st.bw_hz << 1);   // R03

      // fixed gain override when a code other than 000 or 111 is written
      if (st.front_gain_choice != rx_chain_pkg::GAIN_AUTO &&
          st.front_gain_choice != rx_chain_pkg::GAIN_RSVD)
         next_st.gain = st.front_gain_choice;   // R18

      // bus reads
      next_st.rdat = 32'h0;
      if (hit && !wb_req.we)
      begin
         case (a8)
            rx_chain_pkg::OFS_MODULATION:
               next_st.rdat = 32'(st.demod_scheme_select);
            rx_chain_pkg::OFS_BANDWIDTH:
               next_st.rdat = 32'(st.bandwidth_config_reg);
            rx_chain_pkg::OFS_CORR_BW:
               next_st.rdat = 32'(st.correction_bw);
            rx_chain_pkg::OFS_DIGITAL_GAIN:
               next_st.rdat = 32'(st.digital_gain_ctrl_reg);
            rx_chain_pkg::OFS_GAIN_CTRL:
               next_st.rdat = {25'h0, st.front_gain_choice, 4'h0};
            rx_chain_pkg::OFS_WAIT_LEVEL:
               next_st.rdat = 32'(st.signal_wait_level_reg);
            rx_chain_pkg::OFS_STEP_LO:
               next_st.rdat = st.step_levels[31:0];
            rx_chain_pkg::OFS_STEP_HI:
               next_st.rdat = 32'(st.step_levels[39:32]);
            rx_chain_pkg::OFS_STATUS:
               next_st.rdat = {22'h0, 2'(st.dgain), 1'b0, st.gain,
                               1'b0, 3'(st.agc)};
            rx_chain_pkg::OFS_DERIVED:
               next_st.rdat = st.bw_hz;
            rx_chain_pkg::OFS_REFERENCE:
               next_st.rdat = 32'(signed'(ref_db));
            default:
               next_st.rdat = 32'h0;   // unmapped reads as zero
         endcase
      end
   end

   // =====================================================================
   // registers
   // =====================================================================
   // synchronous reset; fixed gain outputs max gain until agc picks
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         st <= '0;
         st.agc <= rx_chain_pkg::ST_WAIT;
         st.gain <= 3'h1;
         st.bandwidth_config_reg <= rx_chain_pkg::RST_BANDWIDTH;
         st.act_bw_cfg <= rx_chain_pkg::RST_BANDWIDTH;
         st.correction_bw <= rx_chain_pkg::RST_CORR_BW;
         st.digital_gain_ctrl_reg <= rx_chain_pkg::RST_DGAIN;
         st.signal_wait_level_reg <= rx_chain_pkg::RST_WAIT;
      end
      else
         st <= next_st;
   end

   // outputs straight from state flops
   assign wb_dat_o = st.rdat;
   assign wb_ack_o = st.ack;
   assign front_gain_step = st.gain;
   assign chan_i = st.out_i;
   assign chan_q = st.out_q;
   assign chan_valid = st.valid;
   assign image_filter_on = st.img_on;
   assign if_offset_hz = st.ifo;
   assign dc_cutoff_hz = st.dcc;

endmodule // rx_gain_and_channel_filter

// >>> rx_chain_pkg.sv
// package: register map, field layouts, states and constants of the rx chain
package rx_chain_pkg;

   // =====================================================================
   // register byte offsets (word aligned)
   // =====================================================================
   localparam logic [7:0] OFS_MODULATION  = 8'h00;
   localparam logic [7:0] OFS_BANDWIDTH   = 8'h04;
   localparam logic [7:0] OFS_CORR_BW     = 8'h08;
   localparam logic [7:0] OFS_DIGITAL_GAIN = 8'h0C;
   localparam logic [7:0] OFS_GAIN_CTRL   = 8'h10;
   localparam logic [7:0] OFS_WAIT_LEVEL  = 8'h14;
   localparam logic [7:0] OFS_STEP_LO     = 8'h18;
   localparam logic [7:0] OFS_STEP_HI     = 8'h1C;
   localparam logic [7:0] OFS_STATUS      = 8'h20;
   localparam logic [7:0] OFS_DERIVED     = 8'h24;
   localparam logic [7:0] OFS_REFERENCE   = 8'h28;

   // =====================================================================
   // field positions and codes
   // =====================================================================
   localparam int MANT_LSB     = 3;
   localparam int DCC_LSB      = 5;
   localparam int REARM_BIT    = 0;
   localparam int CORR_BIT     = 1;
   localparam int LOWIDX_BIT   = 2;
   localparam int DGAIN_ON_BIT = 4;
   localparam logic [1:0] SCHEME_FSK   = 2'h0;
   localparam logic [2:0] GAIN_AUTO    = 3'h0;
   localparam logic [2:0] GAIN_RSVD    = 3'h7;
   localparam logic [7:0] DGAIN_LOWIDX = 8'h10;
   localparam logic [7:0] DGAIN_NORMAL = 8'h30;

   // reset values
   localparam logic [7:0] RST_BANDWIDTH = 8'h55;
   localparam logic [7:0] RST_CORR_BW   = 8'h8B;
   localparam logic [7:0] RST_DGAIN     = 8'h30;
   localparam logic [7:0] RST_WAIT      = 8'hE4;

   // reference level terms in dB, and the crystal frequency in Hz
   localparam int REF_FLOOR_DB   = -174;
   localparam int NOISE_FIG_DB   = 7;
   localparam int DEMOD_SNR_DB   = 8;
   localparam int FADE_DB        = 5;
   localparam int REF_FIXED_DB = REF_FLOOR_DB + NOISE_FIG_DB + DEMOD_SNR_DB
                                 + FADE_DB;
   localparam int XTAL_HZ        = 32000000;

   // fir
   localparam int FIR_TAPS   = 16;
   localparam int DECIM_LOG2 = 4;
   localparam int DGAIN_BITS = 2;

   typedef enum logic [2:0]
   {
      ST_WAIT  = 3'b001,
      ST_PICK  = 3'b010,
      ST_HOLD  = 3'b100
   } agc_state_e;

   typedef struct packed
   {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
      logic        cyc;
      logic        stb;
   } wb_req_s;
endpackage

// >>> rx_chain_properties.sv
// port-level assertions for the rx gain and channel filter
`timescale 1ns/1ps
module rx_chain_properties
(
   input wire logic                  clk_sys,
   input wire logic                  nrst,
   input wire rx_chain_pkg::wb_req_s wb_req,
   input wire logic                  wb_ack_o,
   input wire logic [2:0]            front_gain_step,
   input wire logic                  sample_tick,
   input wire logic                  chan_valid,
   input wire logic                  image_filter_on,
   input wire logic [31:0]           if_offset_hz,
   input wire logic [31:0]           dc_cutoff_hz
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // =====================================================================
   // bus handshake
   // =====================================================================
   sequence s_taken;
      wb_req.cyc && wb_req.stb && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_follows_req : assert property (s_taken |=> s_pulse)
      else $error("ack not a single pulse after request");
   a_ack_has_req : assert property
      (wb_ack_o |-> $past(wb_req.cyc && wb_req.stb && !wb_ack_o))
      else $error("ack without a pending request");

   // =====================================================================
   // gain control
   // =====================================================================
   // cycles since the last level sample or bus answer; gain may only move
   // shortly after one of them, never on its own
   logic [2:0] since;
   always_ff @(posedge clk_sys)
      if (!nrst || sample_tick || wb_ack_o)
         since <= 3'h0;
      else if (since != 3'h7)
         since <= since + 3'h1;
   a_gain_in_range : assert property
      (front_gain_step inside {[3'h1:3'h6]})
      else $error("gain step outside one to six");
   a_gain_has_cause : assert property
      ($changed(front_gain_step) |-> since < 3'h5)
      else $error("gain moved with no sample or write");

   // =====================================================================
   // channel filter output and bandwidth derived values
   // =====================================================================
   sequence s_dump_gap;
      (!chan_valid)[*8] ##1 (!chan_valid)[*7] ##1 chan_valid;
   endsequence
   a_chan_period : assert property (chan_valid |=> s_dump_gap)
      else $error("filter output not every sixteen clocks");
   a_fsk_no_offset : assert property
      ((!image_filter_on)[*3] |-> if_offset_hz == 32'h0)
      else $error("offset present with image filter bypassed");
   // settled values only: the two outputs may refresh a few clocks apart
   a_cutoff_below_if : assert property
      ((image_filter_on && $stable(if_offset_hz) && $stable(dc_cutoff_hz))[*4]
       |-> dc_cutoff_hz < if_offset_hz)
      else $error("dc cutoff not below the intermediate frequency");
endmodule // rx_chain_properties

// >>> tb_rx_gain_and_channel_filter.sv
// self-checking bench for the rx gain and channel filter
`timescale 1ns/1ps
module tb_rx_gain_and_channel_filter;
   logic                  clk_sys = 1'b0;
   logic                  nrst = 1'b0;
   rx_chain_pkg::wb_req_s wb_req = '0;
   logic [31:0]           wb_dat_o;
   logic                  wb_ack_o;
   logic                  adc_i_bit = 1'b0;
   logic                  adc_q_bit = 1'b0;
   logic                  sample_tick = 1'b0;
   logic [7:0]            measured_signal_level = 8'h00;
   logic                  correction_active = 1'b0;
   logic                  packet_gain_frozen = 1'b0;
   logic [2:0]            front_gain_step;
   logic [15:0]           chan_i;
   logic [15:0]           chan_q;
   logic                  chan_valid;
   logic                  image_filter_on;
   logic [31:0]           if_offset_hz;
   logic [31:0]           dc_cutoff_hz;
   logic [31:0]           rd_q;
   logic [7:0]            cfg;
   logic [7:0]            lv;
   logic                  ook;
   logic                  quiet = 1'b0;
   real                   dcc_exp;
   real                   ref_exp;
   int                    bw;
   int                    error_cnt = 0;
   int                    comparisons = 0;

   // bit period shortened so the digital gain steps are seen in a short run;
   // no data stream is sent, so the bit rate may far outrun the bandwidth
   rx_gain_and_channel_filter #(.BIT_CYCLES(8)) dut_u
   (
      .clk_sys(clk_sys), .nrst(nrst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .adc_i_bit(adc_i_bit), .adc_q_bit(adc_q_bit),
      .sample_tick(sample_tick),
      .measured_signal_level(measured_signal_level),
      .correction_active(correction_active),
      .packet_gain_frozen(packet_gain_frozen),
      .front_gain_step(front_gain_step), .chan_i(chan_i), .chan_q(chan_q),
      .chan_valid(chan_valid), .image_filter_on(image_filter_on),
      .if_offset_hz(if_offset_hz), .dc_cutoff_hz(dc_cutoff_hz)
   );

   // =====================================================================
   // clock, free-running converter bits, helpers
   // =====================================================================
   initial
      forever #2.5 clk_sys = ~clk_sys;

   // frozen flag toggles at random: digital gain must not care
   always @(posedge clk_sys)
   begin
      adc_i_bit <= quiet ? 1'b0 : 1'($urandom);   // quiet: zero input
      adc_q_bit <= quiet ? 1'b0 : 1'($urandom);
      packet_gain_frozen <= 1'($urandom);
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic bus(input logic [7:0] adr, input logic we,
                      input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_req <= '{adr: {24'h0, adr}, dat: dat, sel: 4'hF, we: we,
                  cyc: 1'b1, stb: 1'b1};
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      rd_q = wb_dat_o;
      check(32'(n < 20), 32'h1);
      wb_req <= '0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      bus(adr, 1'b1, dat);
   endtask

   task automatic rd(input logic [7:0] adr);
      bus(adr, 1'b0, 32'h0);
   endtask

   task automatic tick(input logic [7:0] level);
      @(posedge clk_sys);
      sample_tick <= 1'b1;
      measured_signal_level <= level;
      @(posedge clk_sys);
      sample_tick <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   function automatic int exp_bw(input logic [7:0] c, input logic o);
      int m;
      m = (c[4:3] == 2'h0) ? 16 : (c[4:3] == 2'h1) ? 20 : 24;
      return rx_chain_pkg::XTAL_HZ / (m * (4 << (int'(c[2:0]) + int'(o))));
   endfunction

   // step levels 30/40/60/80/A0: one step down per level strictly exceeded
   function automatic logic [2:0] exp_gain(input logic [7:0] l);
      return 3'(1 + (l > 8'h30) + (l > 8'h40) + (l > 8'h60) + (l > 8'h80)
                + (l > 8'hA0));
   endfunction

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // =====================================================================
   // main sequence
   // =====================================================================
   initial
   begin
      void'($urandom(32'h5F11AAC8));
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(rx_chain_pkg::OFS_BANDWIDTH);
      check(rd_q & 32'hFF, 32'(rx_chain_pkg::RST_BANDWIDTH));
      rd(rx_chain_pkg::OFS_CORR_BW);
      check(rd_q & 32'hFF, 32'(rx_chain_pkg::RST_CORR_BW));
      rd(rx_chain_pkg::OFS_WAIT_LEVEL);
      check(rd_q & 32'hFF, 32'(rx_chain_pkg::RST_WAIT));
      rd(rx_chain_pkg::OFS_STATUS);
      check(rd_q & 32'h77, 32'h11);
      rd(8'h3C);
      check(rd_q, 32'h0);
      wr(rx_chain_pkg::OFS_DIGITAL_GAIN, 32'(rx_chain_pkg::DGAIN_LOWIDX));
      rd(rx_chain_pkg::OFS_DIGITAL_GAIN);
      check(rd_q & 32'hFF, 32'h10);
      wr(rx_chain_pkg::OFS_DIGITAL_GAIN, 32'(rx_chain_pkg::DGAIN_NORMAL));
      $display("test registers done");

      // settings land only at a decimator dump, so wait past two of them
      for (int i = 0; i < 8; i++)
      begin
         ook = i[0];
         cfg = {3'($urandom_range(0, 7)), 2'(i % 3),
                3'((i < 2) ? i * 7 : $urandom_range(0, 7))};
         wr(rx_chain_pkg::OFS_MODULATION, {31'h0, ook});
         wr(rx_chain_pkg::OFS_BANDWIDTH, 32'(cfg));
         repeat (40) @(posedge clk_sys);
         rd(rx_chain_pkg::OFS_DERIVED);
         bw = exp_bw(cfg, ook);
         check(rd_q, bw);
         check(if_offset_hz, ook ? bw / 2 : 0);
         check(32'(image_filter_on), 32'(ook));
         // cutoff from the exact formula, tolerance a thousandth of bw
         dcc_exp = (4.0 * bw) / (6.2831853 * (4 << cfg[7:5]));
         dcc_exp = (dc_cutoff_hz - dcc_exp) / (bw / 1000 + 2);
         check(32'(dcc_exp > -1.0 && dcc_exp < 1.0), 32'h1);
         // coarse log inside the block may read up to 5 dB low
         rd(rx_chain_pkg::OFS_REFERENCE);
         ref_exp = rx_chain_pkg::REF_FIXED_DB + 10.0 * $log10(2.0 * bw);
         ref_exp = $signed(rd_q) - ref_exp;
         check(32'(ref_exp > -5.0 && ref_exp < 1.0), 32'h1);
      end
      cfg = {6'($urandom_range(0, 63)), 2'h2};
      wr(rx_chain_pkg::OFS_CORR_BW, 32'(cfg));
      correction_active <= 1'b1;
      repeat (40) @(posedge clk_sys);
      rd(rx_chain_pkg::OFS_DERIVED);
      check(rd_q, exp_bw(cfg, ook));
      correction_active <= 1'b0;
      $display("test bandwidth done");

      // silent converters must flush the whole tap line to zero
      quiet <= 1'b1;
      repeat (300) @(posedge clk_sys);
      check(32'(chan_i), 32'h0);
      check(32'(chan_q), 32'h0);
      quiet <= 1'b0;
      // small signals drive the digital gain to its top step
      rd(rx_chain_pkg::OFS_STATUS);
      check((rd_q >> 8) & 32'h3, 32'h3);
      $display("test filter output done");

      wr(rx_chain_pkg::OFS_WAIT_LEVEL, 32'h20);
      wr(rx_chain_pkg::OFS_STEP_LO, 32'h80604030);
      wr(rx_chain_pkg::OFS_STEP_HI, 32'hA0);
      for (int i = 0; i < 8; i++)
      begin
         lv = (i == 0) ? 8'h30 : (i == 1) ? 8'hA1 : 8'($urandom_range(33, 255));
         wr(rx_chain_pkg::OFS_GAIN_CTRL, 32'h1);
         repeat (2) @(posedge clk_sys);
         rd(rx_chain_pkg::OFS_STATUS);
         check(rd_q & 32'h7, 32'h1);
         tick(lv);
         tick(8'h10);
         tick(lv);
         rd(rx_chain_pkg::OFS_STATUS);
         check(rd_q & 32'h7, 32'h1);
         tick(lv);
         rd(rx_chain_pkg::OFS_STATUS);
         check(rd_q & 32'h77, 32'({exp_gain(lv), 4'h4}));
         tick(8'hFF);
         check(32'(front_gain_step), 32'(exp_gain(lv)));
      end
      // reserved code 111 hands back to the loop, which holds step 6
      for (int c = 1; c < 8; c++)
      begin
         wr(rx_chain_pkg::OFS_GAIN_CTRL, 32'(c << 4));
         repeat (3) @(posedge clk_sys);
         check(32'(front_gain_step), 32'((c < 7) ? c : 6));
      end
      wr(rx_chain_pkg::OFS_GAIN_CTRL, 32'h1);
      $display("test gain control done");
      summarize();
   end

   // whole run is a little over a thousand clocks; the 40000-clock limit, over thirty times that, means a hang
   initial
   begin
      #200000;
      error_cnt++;
      summarize();
   end
endmodule // tb_rx_gain_and_channel_filter

bind rx_gain_and_channel_filter rx_chain_properties chk_u
(
   .clk_sys(clk_sys), .nrst(nrst), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
   .front_gain_step(front_gain_step), .sample_tick(sample_tick),
   .chan_valid(chan_valid), .image_filter_on(image_filter_on),
   .if_offset_hz(if_offset_hz), .dc_cutoff_hz(dc_cutoff_hz)
);
